// *** testbench/serial_baud_monitor.sv ***
// concurrent checks on the serial transfer-clock generator ports
`timescale 1ns/10ps
`default_nettype none
`include "serial_baud_consts.vh"
module serial_baud_monitor (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic clockEnable,
   input wire logic [4:0] regAddr,
   input wire logic [15:0] writeData,
   input wire logic writeStrobe,
   input wire logic readStrobe,
   input wire logic [15:0] readData,
   input wire logic extClockPin,
   input wire logic timerOutputClock,
   input wire logic rxPin,
   input wire logic sclkOut,
   input wire logic sclkOutEnable_n,
   input wire logic txdOut,
   input wire logic uartSampleTick,
   input wire logic uartBitTick,
   input wire logic shiftTick,
   input wire logic [3:0] frameBits,
   input wire logic parityEnabled,
   input wire logic wakeupEnabled
);
   logic [6:0] ctl;
   logic [3:0] frac;
   logic [9:0] mode;
   logic [7:0] quiet;
   logic [15:0] gap;
   logic [4:0] bitGap;
   logic armed, bitSeen;
   int n, per;
   wire logic write = writeStrobe && clockEnable;
   wire logic uart = mode[1:0] != `MODE_SYNC;
   wire logic [1:0] src = mode[3:2];
   wire logic settled = quiet > 8'h08;
   // the design drops the fraction for N of 1 or 16 and in synchronous mode
   wire logic fracOn = ctl[6] && uart && ctl[3:0] > 4'h1 && frac != 4'h0;
   // shadow of the programmed setup, so the rates can be judged at the ports
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         ctl <= `BAUD_CONTROL_RESET;
         frac <= `BAUD_FRACTION_RESET;
         mode <= `MODE_RESET;
         quiet <= 8'h00;
         armed <= 1'b0;
         bitSeen <= 1'b0;
         gap <= 16'h0000;
         bitGap <= 5'h00;
      end else if (clockEnable) begin
         quiet <= write ? 8'h00 : quiet + {7'h00, quiet != 8'hff};
         if (write && regAddr == `OFFSET_BAUD_CONTROL) ctl <= writeData[6:0];
         if (write && regAddr == `OFFSET_BAUD_FRACTION) frac <= writeData[3:0];
         if (write && regAddr == `OFFSET_MODE) mode <= writeData[9:0];
         // first period after a write may carry the old divider phase
         armed <= !write && (armed || (uartSampleTick && quiet > 8'h04));
         bitSeen <= !write && (bitSeen || uartBitTick);
         gap <= uartSampleTick ? 16'h0001 : gap + 16'h0001;
         bitGap <= uartBitTick ? 5'h00 : bitGap + {4'h0, uartSampleTick};
      end
   end
   always_comb begin
      n = (ctl[3:0] == 4'h0) ? 16 : int'(ctl[3:0]);
      per = (2 << mode[7:6]) << (2 * ctl[5:4]);
   end
   default clocking dc @(posedge mclk); endclocking
   default disable iff (!reset_n);
   sequence s_half_gap;
      !uartSampleTick ##1 uartSampleTick;
   endsequence
   sequence s_tick_soon;
      ##[1:5] uartSampleTick;
   endsequence
   a_read_data_idle: assert property (!readStrobe |=> readData == 16'h0000)
      else $error("read data not zero outside a read answer");
   a_generator_period: assert property (uart && src == `SRC_GENERATOR && settled
      && armed && uartSampleTick |-> gap == 16'(n * per) || (fracOn && gap == 16'(n * per + per)))
      else $error("generator tick spacing wrong");
   a_bit_sixteen: assert property (uart && bitSeen && uartBitTick |->
      bitGap + {4'h0, uartSampleTick} == 5'h10)
      else $error("bit tick not every sixteenth basic tick");
   a_sys_half: assert property (uart && src == `SRC_SYS_HALF && settled && uartSampleTick
      |=> s_half_gap)
      else $error("half system clock source not every second cycle");
   a_timer_tick: assert property (uart && src == `SRC_TIMER && settled
      && $rose(timerOutputClock) |=> uartSampleTick)
      else $error("timer edge gave no basic tick");
   a_ext_tick: assert property (uart && src == `SRC_EXTERNAL && settled
      && $rose(extClockPin) |-> s_tick_soon)
      else $error("external edge gave no basic tick");
   a_drive_enable: assert property (quiet > 8'h01 |-> sclkOutEnable_n ==
      !(mode[1:0] == `MODE_SYNC && !mode[4]))
      else $error("shift clock drive enable wrong");
   a_frame_len: assert property (quiet > 8'h01 |-> frameBits ==
      (mode[1:0] == `MODE_UART7 ? 4'h7 : mode[1:0] == `MODE_UART9 ? 4'h9 : 4'h8)
      && parityEnabled == (mode[8] && (mode[1:0] == `MODE_UART7 || mode[1:0] == `MODE_UART8))
      && wakeupEnabled == (mode[9] && mode[1:0] == `MODE_UART9))
      else $error("frame length or option flags wrong");
endmodule // serial_baud_monitor
bind serial_baud_clock_generator serial_baud_monitor i_monitor (.*);
`default_nettype wire

// *** testbench/serial_peer_model.sv ***
// synchronous serial peer and external clock source
`timescale 1ns/10ps
`default_nettype none
module serial_peer_model (
   input wire logic mclk,
   input wire logic sclkOut,
   input wire logic sclkOutEnable_n,
   input wire logic txdOut,
   input wire logic [7:0] sendByte,
   input wire logic [7:0] extHalf,
   output logic rxPin,
   output logic extClockPin,
   output logic [7:0] gotByte
);
   logic lastSclk = 1'b1;
   logic lastTxd = 1'b1;
   logic [3:0] bitCount = 4'h0;
   logic [7:0] extCnt = 8'h00;
   initial begin
      rxPin = 1'b1;
      extClockPin = 1'b0;
      gotByte = 8'h00;
   end
   always @(posedge mclk) begin
      lastSclk <= sclkOut;
      lastTxd <= txdOut;
      if (!sclkOutEnable_n && sclkOut && !lastSclk) begin
         gotByte <= {lastTxd, gotByte[7:1]};
         bitCount <= bitCount + 4'h1;
      end
      // outside the frame the line keeps moving, never a stale bit
      if (bitCount < 4'h8) rxPin <= sendByte[bitCount[2:0]];
      else rxPin <= ~rxPin;
      // stands still when stopped; period is twice extHalf cycles
      if (extHalf == 8'h00) extCnt <= 8'h00;
      else if (extCnt + 8'h01 >= extHalf) begin
         extClockPin <= ~extClockPin;
         extCnt <= 8'h00;
      end else extCnt <= extCnt + 8'h01;
   end
endmodule // serial_peer_model
`default_nettype wire

// *** testbench/tb_top.sv ***
// self-checking bench for the serial transfer-clock generator
`timescale 1ns/10ps
`default_nettype none
`include "serial_baud_consts.vh"
module tb_top;
   logic mclk = 1'b0;
   logic reset_n = 1'b0;
   logic clockEnable = 1'b1;
   logic [4:0] regAddr = 5'h00;
   logic [15:0] writeData = 16'h0000;
   logic writeStrobe = 1'b0;
   logic readStrobe = 1'b0;
   logic timerOutputClock = 1'b0;
   logic [7:0] timerHalf = 8'h00;
   logic [7:0] tmrCnt = 8'h00;
   logic [7:0] sendByte = 8'h00;
   logic [7:0] extHalf = 8'h00;
   logic [15:0] readData;
   logic extClockPin, rxPin, sclkOut, sclkOutEnable_n, txdOut;
   logic uartSampleTick, uartBitTick, shiftTick, parityEnabled, wakeupEnabled;
   logic [3:0] frameBits;
   logic [7:0] gotByte, b;
   logic [31:0] notes[$];
   logic [31:0] note;
   logic [15:0] d;
   logic readSeen = 1'b0;
   int fail_count = 0;
   int cmp_count = 0;
   int c, n, k, s, t, i;
   always #10 mclk = ~mclk;
   serial_baud_clock_generator i_dut (.*);
   serial_peer_model i_peer (
      .mclk(mclk),
      .sclkOut(sclkOut),
      .sclkOutEnable_n(sclkOutEnable_n),
      .txdOut(txdOut),
      .sendByte(sendByte),
      .extHalf(extHalf),
      .rxPin(rxPin),
      .extClockPin(extClockPin),
      .gotByte(gotByte)
   );
   always @(posedge mclk) begin
      tmrCnt <= (tmrCnt + 8'h01 >= timerHalf) ? 8'h00 : tmrCnt + 8'h01;
      if (timerHalf != 8'h00 && tmrCnt + 8'h01 >= timerHalf) timerOutputClock <= ~timerOutputClock;
   end
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk_count(input string what, input int exp, input int got);
      cmp_count++;
      if (got != exp) begin
         fail_count++;
         $display("ERROR %s expected %0d seen %0d", what, exp, got);
      end
   endtask
   task automatic chk_reg(input string what, input logic [15:0] exp, input logic [15:0] got);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [15:0] v);
      regAddr <= a;
      writeData <= v;
      writeStrobe <= 1'b1;
      @(posedge mclk);
      writeStrobe <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic rd(input logic [4:0] a, input logic [15:0] e, input logic [15:0] m);
      notes.push_back({m, e});
      regAddr <= a;
      readStrobe <= 1'b1;
      @(posedge mclk);
      readStrobe <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic setup(input logic [15:0] m, input logic [15:0] ctl, input logic [15:0] f);
      wr(`OFFSET_MODE, m);
      wr(`OFFSET_BAUD_CONTROL, ctl);
      wr(`OFFSET_BAUD_FRACTION, f);
   endtask
   function automatic logic pick(input int w);
      return w == 0 ? uartSampleTick : (w == 1 ? uartBitTick : shiftTick);
   endfunction
   // cycles spanned by ticks pulses, after skipping the first ones
   task automatic measure(input int w, input int skip, input int ticks, output int cnt);
      int seen;
      int guard;
      seen = 0;
      guard = 0;
      cnt = 0;
      while (seen < skip + ticks && guard < 30000) begin
         @(negedge mclk);
         guard++;
         if (seen >= skip) cnt++;
         if (pick(w)) seen++;
      end
      @(posedge mclk);
   endtask
   always @(posedge mclk) readSeen <= readStrobe;
   always @(negedge mclk) begin
      if (readSeen) begin
         note = notes.pop_front();
         chk_reg("readData", note[15:0] & note[31:16], readData & note[31:16]);
      end
   end
   initial begin
      repeat (40000) @(posedge mclk);
      fail_count++;
      end_sim();
   end
   initial begin
      n = $urandom(8);
      repeat (8) @(posedge mclk);
      reset_n <= 1'b1;
      @(posedge mclk);
      rd(`OFFSET_BAUD_CONTROL, 16'h0001, 16'hffff);
      rd(`OFFSET_BAUD_FRACTION, 16'h0000, 16'hffff);
      rd(`OFFSET_MODE, 16'h0000, 16'hffff);
      rd(5'h1c, 16'h0000, 16'hffff);
      d = 16'($urandom);
      wr(`OFFSET_BAUD_CONTROL, d);
      rd(`OFFSET_BAUD_CONTROL, d & 16'h007f, 16'hffff);
      wr(`OFFSET_BAUD_FRACTION, d);
      rd(`OFFSET_BAUD_FRACTION, d & 16'h000f, 16'hffff);
      for (i = 0; i < 5; i++) begin
         s = 1 - i % 2;
         t = i % 4;
         n = (i == 4) ? 16 : 1 + int'($urandom % 4);
         setup(16'(s << 6) | 16'h0002, 16'(t << 4) | 16'(n % 16), 16'h0000);
         measure(0, 2, 4, c);
         chk_count("generator span", 4 * n * ((2 << s) << (2 * t)), c);
      end
      rd(`OFFSET_STATUS, 16'h0002, 16'h0002);
      for (i = 0; i < 4; i++) begin
         n = (i == 3) ? 1 : 2 + int'($urandom % 14);
         k = 1 + int'($urandom % 15);
         setup(16'h0042, (i == 3) ? 16'h0001 : 16'h0040 | 16'(n), 16'(k));
         measure(0, 2, 16, c);
         chk_count("fraction span", 4 * ((i == 3) ? 16 : 16 * n + 16 - k), c);
      end
      setup(16'h0006, 16'h0001, 16'h0000);
      measure(0, 2, 16, c);
      chk_count("half clock span", 32, c);
      measure(1, 1, 1, c);
      chk_count("bit span", 32, c);
      timerHalf <= 8'h03;
      wr(`OFFSET_MODE, 16'h000a);
      rd(`OFFSET_STATUS, 16'h0000, 16'h0002);
      measure(0, 2, 16, c);
      chk_count("timer span", 96, c);
      timerHalf <= 8'h00;
      extHalf <= 8'h01;
      wr(`OFFSET_MODE, 16'h000e);
      repeat (20) @(posedge mclk);
      rd(`OFFSET_STATUS, 16'h0001, 16'h0003);
      extHalf <= 8'h04;
      repeat (20) @(posedge mclk);
      wr(`OFFSET_STATUS, 16'h0001);
      measure(0, 2, 16, c);
      chk_count("external span", 128, c);
      rd(`OFFSET_STATUS, 16'h0000, 16'h0001);
      extHalf <= 8'h00;
      sendByte <= 8'($urandom);
      b = 8'($urandom);
      setup(16'h0040, 16'h0008, 16'h0000);
      wr(`OFFSET_SHIFT_DATA, {8'h00, b});
      measure(2, 1, 7, c);
      chk_count("shift span", 448, c);
      repeat (40) @(posedge mclk);
      chk_reg("peer byte", {8'h00, b}, {8'h00, gotByte});
      rd(`OFFSET_SHIFT_DATA, {8'h00, sendByte}, 16'h00ff);
      // shift clock taken from the pin: legal period 16, then too fast with buffering
      extHalf <= 8'h08;
      wr(`OFFSET_MODE, 16'h0010);
      wr(`OFFSET_SHIFT_DATA, {8'h00, b});
      measure(2, 1, 7, c);
      chk_count("external shift span", 112, c);
      rd(`OFFSET_STATUS, 16'h0000, 16'h0003);
      extHalf <= 8'h05;
      wr(`OFFSET_MODE, 16'h0030);
      repeat (40) @(posedge mclk);
      rd(`OFFSET_STATUS, 16'h0001, 16'h0001);
      extHalf <= 8'h00;
      for (i = 0; i < 4; i++) begin
         d = 16'(i) | 16'h0040 | (16'($urandom % 4) << 8);
         wr(`OFFSET_MODE, d);
         @(negedge mclk);
         chk_reg("frame", {10'h000, (i == 1) ? 4'h7 : (i == 3) ? 4'h9 : 4'h8,
            d[8] && (i == 1 || i == 2), d[9] && i == 3},
            {10'h000, frameBits, parityEnabled, wakeupEnabled});
         @(posedge mclk);
      end
      end_sim();
   end
endmodule // tb_top
`default_nettype wire

// *** verilog/baud_frac_divider.v ***
// integer and fractional divider of the baud rate generator
`timescale 1ns/10ps
`default_nettype none
`include "serial_baud_consts.vh"

module baud_frac_divider (
   input wire mclk,
   input wire reset_n,
   input wire clockEnable,
   input wire clear,
   input wire tickIn,
   input wire [3:0] divisorN,
   input wire [3:0] fractionK,
   input wire fractionEnable,
   output reg tickOut
);

   reg [4:0] count;
   reg [3:0] accum;
   reg extra;
   wire [4:0] baseN;
   wire [4:0] addend;
   wire [4:0] sum;
   wire [4:0] lastCount;
   wire useFraction;

   assign baseN = (divisorN == 4'h0) ? 5'h10 : {1'b0, divisorN};
   // N of 1 or 16 never takes the fraction, whatever the enable says
   assign useFraction = fractionEnable && (fractionK != 4'h0) &&
      (divisorN != 4'h0) && (divisorN != 4'h1);
   assign addend = 5'h10 - {1'b0, fractionK};
   assign sum = {1'b0, accum} + addend;
   // one extra input cycle in (16-K) of every 16 output periods
   assign lastCount = extra ? baseN : (baseN - 5'h01);

   always @(posedge mclk) begin
      if (!reset_n) begin
         count <= 5'h00;
         accum <= 4'h0;
         extra <= 1'b0;
         tickOut <= 1'b0;
      end else if (clockEnable) begin
         tickOut <= 1'b0;
         if (clear) begin
            count <= 5'h00;
            accum <= 4'h0;
            extra <= 1'b0;
         end else if (tickIn) begin
            if (count >= lastCount) begin
               count <= 5'h00;
               tickOut <= 1'b1;
               if (useFraction) begin
                  accum <= sum[3:0];
                  extra <= sum[4];
               end else begin
                  accum <= 4'h0;
                  extra <= 1'b0;
               end
            end else begin
               count <= count + 5'h01;
            end
         end
      end
   end

endmodule // baud_frac_divider
`default_nettype wire

// *** verilog/serial_baud_clock_generator.v ***
// transfer-clock generation and clock selection for one serial channel
//
// Added by the designer: the register addresses and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
`include "serial_baud_consts.vh"

module serial_baud_clock_generator (
   input wire mclk,
   input wire reset_n,
   input wire clockEnable,
   input wire [`ADDR_WIDTH-1:0] regAddr,
   input wire [`DATA_WIDTH-1:0] writeData,
   input wire writeStrobe,
   input wire readStrobe,
   output reg [`DATA_WIDTH-1:0] readData,
   input wire extClockPin,
   input wire timerOutputClock,
   input wire rxPin,
   output reg sclkOut,
   output reg sclkOutEnable_n,
   output reg txdOut,
   output reg uartSampleTick,
   output reg uartBitTick,
   output reg shiftTick,
   output reg [3:0] frameBits,
   output reg parityEnabled,
   output reg wakeupEnabled
);

   // software-visible state
   reg [6:0] baudControlReg;
   reg [3:0] baudFractionReg;
   reg [9:0] modeReg;
   reg extTooFast;

   // clock path state
   reg [3:0] periphDiv;
   reg [6:0] prescaler;
   reg sysHalf;
   reg timerPrev;
   reg extSync1;
   reg extSync2;
   reg extPrev;
   reg rxSync1;
   reg rxSync2;
   reg [4:0] extGap;
   reg extSeen;
   reg [3:0] overCount;

   // synchronous shifter
   reg [7:0] txShift;
   reg [7:0] rxShift;
   reg [7:0] rxData;
   reg [2:0] bitCount;
   reg shiftBusy;

   wire [3:0] integerDivisorN;
   wire [1:0] generatorTapSelect;
   wire fractionEnable;
   wire [3:0] fractionK;
   wire [1:0] channelMode;
   wire [1:0] uartClockSource;
   wire shiftClockDirection;
   wire doubleBuffer;
   wire [1:0] prescalerInputSelect;
   wire syncMode;
   wire generatorSelected;
   wire extUsed;
   wire prescalerInputClock;
   wire generatorInputTick;
   wire baudTick;
   wire timerRise;
   wire extRise;
   wire [4:0] extPeriod;
   wire sclkRise;
   wire shiftEvent;
   wire writeHit;
   reg uartBasic;
   reg [4:0] extMin;

   assign integerDivisorN = baudControlReg[`DIVISOR_MSB:`DIVISOR_LSB];
   assign generatorTapSelect = baudControlReg[`TAP_MSB:`TAP_LSB];
   assign fractionEnable = baudControlReg[`FRACTION_ENABLE_BIT];
   assign fractionK = baudFractionReg;
   assign channelMode = modeReg[`MODE_MSB:`MODE_LSB];
   assign uartClockSource = modeReg[`SOURCE_MSB:`SOURCE_LSB];
   assign shiftClockDirection = modeReg[`DIRECTION_BIT];
   assign doubleBuffer = modeReg[`DOUBLE_BUFFER_BIT];
   assign prescalerInputSelect = modeReg[`PRESCALE_SEL_MSB:`PRESCALE_SEL_LSB];
   assign syncMode = (channelMode == `MODE_SYNC);
   assign writeHit = clockEnable && writeStrobe;

   // output shift clock in mode 0 or generator source in UART modes
   assign generatorSelected = syncMode ? !shiftClockDirection :
      (uartClockSource == `SRC_GENERATOR);
   assign extUsed = syncMode ? shiftClockDirection :
      (uartClockSource == `SRC_EXTERNAL);

   // prescaler input: mclk divided by 2, 4, 8 or 16
   assign prescalerInputClock = (prescalerInputSelect == 2'h0) ? periphDiv[0] :
      (prescalerInputSelect == 2'h1) ? (&periphDiv[1:0]) :
      (prescalerInputSelect == 2'h2) ? (&periphDiv[2:0]) : (&periphDiv[3:0]);

   // generator taps: prescaler input divided by 1, 4, 16 or 64
   assign generatorInputTick = prescalerInputClock &&
      ((generatorTapSelect == 2'h0) ? 1'b1 :
       (generatorTapSelect == 2'h1) ? (&prescaler[1:0]) :
       (generatorTapSelect == 2'h2) ? (&prescaler[3:0]) : (&prescaler[5:0]));

   baud_frac_divider generator (
      .mclk(mclk),
      .reset_n(reset_n),
      .clockEnable(clockEnable),
      .clear(!generatorSelected),
      .tickIn(generatorInputTick),
      .divisorN(integerDivisorN),
      .fractionK(fractionK),
      .fractionEnable(fractionEnable && !syncMode),
      .tickOut(baudTick)
   );

   assign timerRise = timerOutputClock && !timerPrev;
   assign extRise = extSync2 && !extPrev;
   assign extPeriod = (extGap == 5'h1f) ? extGap : (extGap + 5'h01);
   assign sclkRise = baudTick && !sclkOut && shiftBusy;
   assign shiftEvent = syncMode && shiftBusy &&
      (shiftClockDirection ? extRise : sclkRise);

   // UART basic clock, one pulse per 1/16 bit
   always @* begin
      case (uartClockSource)
         `SRC_GENERATOR: uartBasic = baudTick;
         `SRC_SYS_HALF: uartBasic = sysHalf;
         `SRC_TIMER: uartBasic = timerRise;
         default: uartBasic = extRise;
      endcase
   end

   // shortest legal external period depends on mode and buffering
   always @* begin
      if (!syncMode) begin
         extMin = `EXT_MIN_UART;
      end else if (doubleBuffer) begin
         extMin = `EXT_MIN_SYNC_DBUF;
      end else begin
         extMin = `EXT_MIN_SYNC;
      end
   end

   // pin inputs pass two flip-flops; the first is read only by the second
   always @(posedge mclk) begin
      if (!reset_n) begin
         extSync1 <= 1'b0;
         extSync2 <= 1'b0;
         extPrev <= 1'b0;
         rxSync1 <= 1'b1;
         rxSync2 <= 1'b1;
         timerPrev <= 1'b0;
         sysHalf <= 1'b0;
      end else if (clockEnable) begin
         extSync1 <= extClockPin;
         extSync2 <= extSync1;
         extPrev <= extSync2;
         rxSync1 <= rxPin;
         rxSync2 <= rxSync1;
         timerPrev <= timerOutputClock;
         sysHalf <= !sysHalf;
      end
   end

   // prescaler held cleared unless the generator is in use
   always @(posedge mclk) begin
      if (!reset_n) begin
         periphDiv <= 4'h0;
         prescaler <= 7'h00;
      end else if (clockEnable) begin
         if (!generatorSelected) begin
            periphDiv <= 4'h0;
            prescaler <= 7'h00;
         end else begin
            periphDiv <= periphDiv + 4'h1;
            if (prescalerInputClock) begin
               prescaler <= prescaler + 7'h01;
            end
         end
      end
   end

   // UART oversample counter; the timer is never a synchronous clock
   always @(posedge mclk) begin
      if (!reset_n) begin
         overCount <= 4'h0;
         uartSampleTick <= 1'b0;
         uartBitTick <= 1'b0;
      end else if (clockEnable) begin
         uartSampleTick <= 1'b0;
         uartBitTick <= 1'b0;
         if (syncMode) begin
            overCount <= 4'h0;
         end else if (uartBasic) begin
            uartSampleTick <= 1'b1;
            overCount <= overCount + 4'h1;
            if (overCount == `OVERSAMPLE_LAST) begin
               uartBitTick <= 1'b1;
            end
         end
      end
   end

   // external clock period watch, in system clocks between rising edges
   always @(posedge mclk) begin
      if (!reset_n) begin
         extGap <= 5'h00;
         extSeen <= 1'b0;
      end else if (clockEnable) begin
         if (!extUsed) begin
            extGap <= 5'h00;
            extSeen <= 1'b0;
         end else if (extRise) begin
            extGap <= 5'h00;
            extSeen <= 1'b1;
         end else if (extGap != 5'h1f) begin
            extGap <= extGap + 5'h01;
         end
      end
   end

   // synchronous shifter: sclk idles high and runs only while busy
   always @(posedge mclk) begin
      if (!reset_n) begin
         sclkOut <= 1'b1;
         sclkOutEnable_n <= 1'b1;
         txdOut <= 1'b1;
         shiftTick <= 1'b0;
         txShift <= 8'hff;
         rxShift <= 8'h00;
         rxData <= 8'h00;
         bitCount <= 3'h0;
         shiftBusy <= 1'b0;
      end else if (clockEnable) begin
         shiftTick <= shiftEvent;
         sclkOutEnable_n <= !(syncMode && !shiftClockDirection);
         if (!syncMode || shiftClockDirection) begin
            sclkOut <= 1'b1;
         end else if (baudTick && (shiftBusy || !sclkOut)) begin
            sclkOut <= !sclkOut;
         end
         if (writeStrobe && regAddr == `OFFSET_SHIFT_DATA && syncMode) begin
            txShift <= writeData[7:0];
            txdOut <= writeData[0];
            bitCount <= 3'h0;
            shiftBusy <= 1'b1;
         end else if (shiftEvent) begin
            rxShift <= {rxSync2, rxShift[7:1]};
            txShift <= {1'b1, txShift[7:1]};
            txdOut <= txShift[1];
            bitCount <= bitCount + 3'h1;
            if (bitCount == 3'h7) begin
               shiftBusy <= 1'b0;
               rxData <= {rxSync2, rxShift[7:1]};
            end
         end else if (!syncMode) begin
            shiftBusy <= 1'b0;
            txdOut <= 1'b1;
         end
      end
   end

   // frame options follow the channel mode
   always @(posedge mclk) begin
      if (!reset_n) begin
         frameBits <= 4'h8;
         parityEnabled <= 1'b0;
         wakeupEnabled <= 1'b0;
      end else if (clockEnable) begin
         case (channelMode)
            `MODE_UART7: frameBits <= 4'h7;
            `MODE_UART9: frameBits <= 4'h9;
            default: frameBits <= 4'h8;
         endcase
         parityEnabled <= modeReg[`PARITY_BIT] &&
            (channelMode == `MODE_UART7 || channelMode == `MODE_UART8);
         wakeupEnabled <= modeReg[`WAKEUP_BIT] && (channelMode == `MODE_UART9);
      end
   end

   // register writes; a too-fast edge wins over a clear in the same cycle
   always @(posedge mclk) begin
      if (!reset_n) begin
         baudControlReg <= `BAUD_CONTROL_RESET;
         baudFractionReg <= `BAUD_FRACTION_RESET;
         modeReg <= `MODE_RESET;
         extTooFast <= 1'b0;
      end else if (clockEnable) begin
         if (writeStrobe) begin
            if (regAddr == `OFFSET_BAUD_CONTROL) begin
               baudControlReg <= writeData[6:0];
            end else if (regAddr == `OFFSET_BAUD_FRACTION) begin
               baudFractionReg <= writeData[3:0];
            end else if (regAddr == `OFFSET_MODE) begin
               modeReg <= writeData[9:0];
            end
         end
         if (extUsed && extRise && extSeen && (extPeriod < extMin)) begin
            extTooFast <= 1'b1;
         end else if (writeHit && regAddr == `OFFSET_STATUS &&
                      writeData[`STATUS_EXT_FAST_BIT]) begin
            extTooFast <= 1'b0;
         end
      end
   end

   // read data valid the cycle after the strobe, zero otherwise
   always @(posedge mclk) begin
      if (!reset_n) begin
         readData <= {`DATA_WIDTH{1'b0}};
      end else if (clockEnable) begin
         if (!readStrobe) begin
            readData <= {`DATA_WIDTH{1'b0}};
         end else if (regAddr == `OFFSET_BAUD_CONTROL) begin
            readData <= {9'h000, baudControlReg};
         end else if (regAddr == `OFFSET_BAUD_FRACTION) begin
            readData <= {12'h000, baudFractionReg};
         end else if (regAddr == `OFFSET_MODE) begin
            readData <= {6'h00, modeReg};
         end else if (regAddr == `OFFSET_STATUS) begin
            readData <= {12'h000, shiftBusy, sclkOut, generatorSelected, extTooFast};
         end else if (regAddr == `OFFSET_SHIFT_DATA) begin
            readData <= {8'h00, rxData};
         end else begin
            readData <= {`DATA_WIDTH{1'b0}};
         end
      end
   end

   // one channel per instance; no state is shared between channels

endmodule // serial_baud_clock_generator
`default_nettype wire

// *** verilog/serial_baud_consts.vh ***
// constants for the serial channel transfer-clock generator
`ifndef SERIAL_BAUD_CONSTS_VH
`define SERIAL_BAUD_CONSTS_VH

`define ADDR_WIDTH 5
`define DATA_WIDTH 16

`define OFFSET_BAUD_CONTROL 5'h00
`define OFFSET_BAUD_FRACTION 5'h04
`define OFFSET_MODE 5'h08
`define OFFSET_STATUS 5'h0c
`define OFFSET_SHIFT_DATA 5'h10

// baud_control_reg fields
`define DIVISOR_LSB 0
`define DIVISOR_MSB 3
`define TAP_LSB 4
`define TAP_MSB 5
`define FRACTION_ENABLE_BIT 6
`define BAUD_CONTROL_RESET 7'h01
`define BAUD_FRACTION_RESET 4'h0

// mode register fields
`define MODE_LSB 0
`define MODE_MSB 1
`define SOURCE_LSB 2
`define SOURCE_MSB 3
`define DIRECTION_BIT 4
`define DOUBLE_BUFFER_BIT 5
`define PRESCALE_SEL_LSB 6
`define PRESCALE_SEL_MSB 7
`define PARITY_BIT 8
`define WAKEUP_BIT 9
`define MODE_RESET 10'h000

// status register fields
`define STATUS_EXT_FAST_BIT 0
`define STATUS_PRESCALER_BIT 1
`define STATUS_SCLK_BIT 2
`define STATUS_BUSY_BIT 3

// channel modes
`define MODE_SYNC 2'h0
`define MODE_UART7 2'h1
`define MODE_UART8 2'h2
`define MODE_UART9 2'h3

// UART clock sources
`define SRC_GENERATOR 2'h0
`define SRC_SYS_HALF 2'h1
`define SRC_TIMER 2'h2
`define SRC_EXTERNAL 2'h3

// timing: oversample count in basic ticks, external periods in system clock periods
`define OVERSAMPLE_LAST 4'hf
`define EXT_MIN_UART 5'h04
`define EXT_MIN_SYNC_DBUF 5'h0c
`define EXT_MIN_SYNC 5'h10

`endif
